/* File: common/plcap_pkg.sv */
// plcap_pkg: constants for the link capability register block
`default_nettype none
package plcap_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [11:0] LINK_CAPABILITIES_OFS = 12'h0EC; // cfg offset
	localparam logic [7:0]  NVM_ASPM_WORD         = 8'h1A;   // aspm word
	localparam logic [7:0]  NVM_LAT_WORD          = 8'h18;   // latency word
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int SPEED_LSB  = 0;
	localparam int WIDTH_LSB  = 4;
	localparam int ASPM_LSB   = 10;
	localparam int L0S_LSB    = 12;
	localparam int L1_LSB     = 15;
	localparam int SDERR_BIT  = 19;
	localparam int DLLA_BIT   = 20;
	localparam int PORT_LSB   = 24;
	// nvm word sub-fields
	localparam int NV_L0S_COMMON_LSB   = 0;
	localparam int NV_L0S_SEPARATE_LSB = 3;
	localparam int NV_L1_LSB           = 6;
	localparam int NV_ASPM_LSB         = 0;
	// ------------------------------------------------------------
	// fixed values and reset values
	// ------------------------------------------------------------
	localparam logic [3:0] SPEED_2G5     = 4'h1;  // 2.5 gb/s
	localparam logic [5:0] WIDTH_X1      = 6'h01; // single lane
	localparam logic [1:0] ASPM_RESET    = 2'h3;  // l0s and l1
	localparam logic [2:0] L0S_RESET     = 3'h1;  // 64-128 ns
	localparam logic [2:0] L1_RESET      = 3'h6;  // 32-64 us
	localparam logic [2:0] LAT_RESERVED  = 3'h7;  // l0s reserved code
	localparam logic [7:0] PORT_RESET    = 8'h00; // before training
	localparam logic       CAP_ABSENT    = 1'h0;  // optional caps
	// ------------------------------------------------------------
	// load sequencer timing
	// ------------------------------------------------------------
	localparam int LOAD_WAIT_CYCLES = 2; // nvm read answer latency
endpackage : plcap_pkg
`default_nettype wire

/* File: verilog/plcap_nvm_loader.sv */
// plcap_nvm_loader: fetches the two nvm words after reset
`timescale 1ns/1ps
`default_nettype none
module plcap_nvm_loader (
	input  wire logic       clk_sys,   // system clock
	input  wire logic       rst,       // sync reset, high
	output logic            nvm_rd,    // nvm read strobe
	output logic [7:0]      nvm_addr,  // nvm word address
	input  wire logic       nvm_ack,   // nvm data valid
	input  wire logic [15:0] nvm_data, // nvm word
	output logic            aspm_we,   // aspm word captured
	output logic            lat_we,    // latency word captured
	output logic [15:0]     word,      // captured word
	output logic            done       // both words loaded
);
	typedef enum logic [2:0] {
		PLCAP_RD_ASPM, PLCAP_WT_ASPM, PLCAP_RD_LAT, PLCAP_WT_LAT,
		PLCAP_DONE
	} plcap_ld_t;
	plcap_ld_t state;

	// ------------------------------------------------------------
	// fetch sequence
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state <= PLCAP_RD_ASPM;
		end else begin
			case (state)
				PLCAP_RD_ASPM: state <= PLCAP_WT_ASPM;
				PLCAP_WT_ASPM: if (nvm_ack) state <= PLCAP_RD_LAT;
				PLCAP_RD_LAT:  state <= PLCAP_WT_LAT;
				PLCAP_WT_LAT:  if (nvm_ack) state <= PLCAP_DONE;
				PLCAP_DONE:    state <= PLCAP_DONE;
				default:       state <= PLCAP_RD_ASPM;
			endcase
		end
	end

	// captured word register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			word <= 16'h0000;
		end else if (nvm_ack) begin
			word <= nvm_data;
		end
	end

	// strobes and address
	always_comb begin
		nvm_rd   = (state == PLCAP_RD_ASPM) || (state == PLCAP_RD_LAT);
		nvm_addr = (state == PLCAP_RD_ASPM || state == PLCAP_WT_ASPM) ?
			plcap_pkg::NVM_ASPM_WORD : plcap_pkg::NVM_LAT_WORD;
	end

	// write pulses one cycle after the ack, in the same cycle as the captured word
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			aspm_we <= 1'b0;
			lat_we  <= 1'b0;
		end else begin
			aspm_we <= (state == PLCAP_WT_ASPM) && nvm_ack;
			lat_we  <= (state == PLCAP_WT_LAT) && nvm_ack;
		end
	end

	assign done = (state == PLCAP_DONE) && !lat_we;
endmodule : plcap_nvm_loader
`default_nettype wire

/* File: verilog/plcap_sync3.sv */
// plcap_sync3: three-stage synchroniser with agreement detect
`timescale 1ns/1ps
`default_nettype none
module plcap_sync3 (
	input  wire logic clk_sys, // system clock
	input  wire logic rst,     // sync reset, high
	input  wire logic din,     // asynchronous level
	output logic      dout     // filtered level
);
	logic s1;
	logic s2;
	logic s3;

	// stage chain; s1 feeds only s2
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// output follows once stages two and three agree
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dout <= 1'b0;
		end else if (s2 == s3) begin
			dout <= s3;
		end
	end
endmodule : plcap_sync3
`default_nettype wire

/* File: verilog/plcap_link_capabilities.sv */
// plcap_link_capabilities: read-only link capability config register
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1 - speed field fixed at 2.5 Gb/s code
// R2 - width field fixed at x1 code
// R3 - aspm support two bits, reset both
// R4 - aspm support loaded from nvm word 0x1A
// R5 - l0s latency three bits, reset 001b
// R6 - l0s from 0x18, common or separate bits
// R7 - l1 latency from 0x18, reset 110b
// R8 - surprise down capable reads zero
// R9 - link active reporting capable reads zero
// R10 - port number captured in training
// R11 - register read-only, reserved bits zero
// R12 - host common clock bit picks l0s
// R13 - nvm fields valid before first read
module plcap_link_capabilities (
	input  wire logic        clk_sys,      // system clock
	input  wire logic        rst,          // sync reset, high
	input  wire logic        cfg_rd,       // config read request
	input  wire logic        cfg_wr,       // config write request
	input  wire logic [11:0] cfg_addr,     // config byte offset
	input  wire logic [31:0] cfg_wdata,    // config write data
	output logic             cfg_ack,      // read/write answered
	output logic [31:0]      cfg_rdata,    // read data
	input  wire logic        common_clk,   // link control common clock
	input  wire logic        link_training,// training in progress
	input  wire logic        port_valid,   // port number strobe
	input  wire logic [7:0]  port_num,     // trained port number
	output logic             nvm_rd,       // nvm read strobe
	output logic [7:0]       nvm_addr,     // nvm word address
	input  wire logic        nvm_ack,      // nvm data valid
	input  wire logic [15:0] nvm_data,     // nvm word
	output logic             cap_ready     // nvm fields loaded
);
	// ------------------------------------------------------------
	// held fields
	// ------------------------------------------------------------
	logic [1:0]  aspm;
	logic [2:0]  l0s_common;
	logic [2:0]  l0s_separate;
	logic [2:0]  l1_lat;
	logic [7:0]  port;
	logic        aspm_we;
	logic        lat_we;
	logic [15:0] ld_word;
	logic        ld_done;
	logic        train_s;
	logic        pend;
	logic        pend_wr;
	logic [11:0] pend_addr;
	logic [31:0] cap_word;

	plcap_nvm_loader u_loader (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.nvm_rd   (nvm_rd),
		.nvm_addr (nvm_addr),
		.nvm_ack  (nvm_ack),
		.nvm_data (nvm_data),
		.aspm_we  (aspm_we),
		.lat_we   (lat_we),
		.word     (ld_word),
		.done     (ld_done)
	);

	// training indication arrives from the phy domain
	plcap_sync3 u_train_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.din     (link_training),
		.dout    (train_s)
	);

	// aspm support from its nvm word
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			aspm <= plcap_pkg::ASPM_RESET; // see R3
		end else if (aspm_we) begin
			aspm <= ld_word[plcap_pkg::NV_ASPM_LSB +: 2]; // see R4
		end
	end

	// both l0s candidates and l1 from latency word
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			l0s_common   <= plcap_pkg::L0S_RESET; // see R5
			l0s_separate <= plcap_pkg::L0S_RESET;
			l1_lat       <= plcap_pkg::L1_RESET; // see R7
		end else if (lat_we) begin
			l0s_common   <= ld_word[plcap_pkg::NV_L0S_COMMON_LSB +: 3];
			l0s_separate <= ld_word[plcap_pkg::NV_L0S_SEPARATE_LSB +: 3];
			l1_lat       <= ld_word[plcap_pkg::NV_L1_LSB +: 3]; // see R7
		end
	end

	// port number captured while training
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			port <= plcap_pkg::PORT_RESET;
		end else if (train_s && port_valid) begin
			port <= port_num; // see R10
		end
	end

	// ------------------------------------------------------------
	// register image
	// ------------------------------------------------------------
	always_comb begin
		cap_word = 32'h0000_0000; // reserved bits zero, see R11
		cap_word[plcap_pkg::SPEED_LSB +: 4] = plcap_pkg::SPEED_2G5; // see R1
		cap_word[plcap_pkg::WIDTH_LSB +: 6] = plcap_pkg::WIDTH_X1; // see R2
		cap_word[plcap_pkg::ASPM_LSB +: 2]  = aspm; // see R3
		// host clock mode picks the l0s value, see R6 and R12
		cap_word[plcap_pkg::L0S_LSB +: 3] = common_clk ?
			l0s_common : l0s_separate;
		cap_word[plcap_pkg::L1_LSB +: 3] = l1_lat;
		cap_word[plcap_pkg::SDERR_BIT] = plcap_pkg::CAP_ABSENT; // see R8
		cap_word[plcap_pkg::DLLA_BIT]  = plcap_pkg::CAP_ABSENT; // see R9
		cap_word[plcap_pkg::PORT_LSB +: 8] = port; // see R10
	end

	assign cap_ready = ld_done;

	// ------------------------------------------------------------
	// config access: held until loading ends
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pend      <= 1'b0;
			pend_wr   <= 1'b0;
			pend_addr <= 12'h000;
		end else if (!pend && (cfg_rd || cfg_wr) && !ld_done) begin
			pend      <= 1'b1; // see R13
			pend_wr   <= cfg_wr;
			pend_addr <= cfg_addr; // offset kept for the late answer
		end else if (pend && ld_done) begin
			pend <= 1'b0;
		end
	end

	// answers; writes change nothing, see R11
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cfg_ack   <= 1'b0;
			cfg_rdata <= 32'h0000_0000;
		end else begin
			cfg_ack   <= 1'b0;
			cfg_rdata <= 32'h0000_0000;
			if (ld_done && (pend || cfg_rd || cfg_wr)) begin
				cfg_ack <= 1'b1;
				if ((pend ? !pend_wr : cfg_rd) &&
					(pend ? pend_addr : cfg_addr) ==
					plcap_pkg::LINK_CAPABILITIES_OFS) begin
					cfg_rdata <= cap_word; // see R13
				end
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence plcap_rd_seq;
		cfg_rd && ld_done && !pend &&
			cfg_addr == plcap_pkg::LINK_CAPABILITIES_OFS;
	endsequence

	AST_SPEED: assert property (@(posedge clk_sys) disable iff (rst) // see R1
		plcap_rd_seq |=> cfg_rdata[3:0] == 4'h1)
		else $error("speed field wrong");
	AST_WIDTH: assert property (@(posedge clk_sys) disable iff (rst) // see R2
		plcap_rd_seq |=> cfg_rdata[9:4] == 6'h01)
		else $error("width field wrong");
	AST_ASPM_RST: assert property (@(posedge clk_sys) // see R3
		rst |=> aspm == 2'h3)
		else $error("aspm reset wrong");
	AST_ASPM_LOAD: assert property (@(posedge clk_sys) disable iff (rst) // see R4
		aspm_we |=> aspm == $past(ld_word[1:0]))
		else $error("aspm not loaded");
	AST_L0S_SEL: assert property (@(posedge clk_sys) disable iff (rst) // see R6
		plcap_rd_seq |=> cfg_rdata[14:12] ==
			($past(common_clk) ? $past(l0s_common) : $past(l0s_separate)))
		else $error("l0s selection wrong");
	AST_L1_LOAD: assert property (@(posedge clk_sys) disable iff (rst) // see R7
		lat_we |=> l1_lat == $past(ld_word[8:6]))
		else $error("l1 not loaded");
	AST_OPT_ZERO: assert property (@(posedge clk_sys) disable iff (rst) // see R8
		plcap_rd_seq |=> cfg_rdata[20:18] == 3'h0)
		else $error("optional caps not zero");
	AST_RSVD: assert property (@(posedge clk_sys) disable iff (rst) // see R11
		cfg_ack |-> cfg_rdata[23:21] == 3'h0)
		else $error("reserved bits set");
	AST_PORT_HOLD: assert property (@(posedge clk_sys) disable iff (rst) // see R10
		!(train_s && port_valid) |=> port == $past(port))
		else $error("port changed outside training");
	AST_EARLY: assert property (@(posedge clk_sys) disable iff (rst) // see R13
		!ld_done |=> !cfg_ack)
		else $error("answered before load");

	// ------------------------------------------------------------
	// load sequence and access checks
	// ------------------------------------------------------------
	// fetch of the aspm word
	sequence plcap_fetch_aspm_seq;
		nvm_rd && nvm_addr == plcap_pkg::NVM_ASPM_WORD;
	endsequence
	// fetch of the latency word
	sequence plcap_fetch_lat_seq;
		nvm_rd && nvm_addr == plcap_pkg::NVM_LAT_WORD;
	endsequence
	// request arriving while the nvm words are still loading
	sequence plcap_early_seq;
		(cfg_rd || cfg_wr) && !ld_done && !pend;
	endsequence

	AST_FETCH_FIRST: assert property (@(posedge clk_sys) // see R4
		rst ##1 !rst |-> plcap_fetch_aspm_seq)
		else $error("first fetch not aspm word");
	AST_FETCH_LAT: assert property (@(posedge clk_sys) disable iff (rst) // see R6
		aspm_we |-> plcap_fetch_lat_seq)
		else $error("latency word not fetched next");
	AST_LAT_RST: assert property (@(posedge clk_sys) // see R5
		rst |=> l0s_common == plcap_pkg::L0S_RESET &&
			l0s_separate == plcap_pkg::L0S_RESET &&
			l1_lat == plcap_pkg::L1_RESET)
		else $error("latency reset wrong");
	AST_PORT_RST: assert property (@(posedge clk_sys) // see R10
		rst |=> port == plcap_pkg::PORT_RESET)
		else $error("port reset wrong");
	AST_PORT_TAKE: assert property (@(posedge clk_sys) disable iff (rst) // see R10
		train_s && port_valid |=> port == $past(port_num))
		else $error("port not captured in training");
	AST_READY: assert property (@(posedge clk_sys) disable iff (rst) // see R13
		lat_we |=> ld_done)
		else $error("ready late after last load");
	AST_PEND_TAKE: assert property (@(posedge clk_sys) disable iff (rst) // see R13
		plcap_early_seq |=> pend)
		else $error("early request not held");
	AST_PEND_ANS: assert property (@(posedge clk_sys) disable iff (rst) // see R13
		pend && ld_done |=> cfg_ack)
		else $error("held request not answered");
	AST_WR_ZERO: assert property (@(posedge clk_sys) disable iff (rst) // see R11
		cfg_wr && ld_done && !pend |=> cfg_ack && cfg_rdata == 32'h0000_0000)
		else $error("write answer wrong");
	AST_OTHER_ZERO: assert property (@(posedge clk_sys) disable iff (rst) // see R11
		cfg_rd && ld_done && !pend &&
			cfg_addr != plcap_pkg::LINK_CAPABILITIES_OFS
			|=> cfg_rdata == 32'h0000_0000)
		else $error("other offset not zero");
	AST_IDLE_ZERO: assert property (@(posedge clk_sys) disable iff (rst) // see R11
		!cfg_ack |-> cfg_rdata == 32'h0000_0000)
		else $error("read data outside answer");
	AST_IMAGE_STABLE: assert property (@(posedge clk_sys) disable iff (rst) // see R11
		ld_done && !(train_s && port_valid) ##1 $stable(common_clk)
			|-> $stable(cap_word))
		else $error("image changed without cause");
endmodule : plcap_link_capabilities
`default_nettype wire

/* File: sim/plcap_nvm_model.sv */
// plcap_nvm_model: nvm word store answering the loader's fetches
`timescale 1ns/1ps
`default_nettype none
module plcap_nvm_model #(
	parameter logic [15:0] ASPM_WORD = 16'h0001, // aspm word content
	parameter logic [15:0] LAT_WORD  = 16'h012A  // latency word content
) (
	input  wire logic        clk_sys,  // system clock
	input  wire logic        rst,      // sync reset, high
	input  wire logic        nvm_rd,   // read strobe
	input  wire logic [7:0]  nvm_addr, // word address
	output logic             nvm_ack,  // data valid pulse
	output logic [15:0]      nvm_data  // word out
);
	logic       busy;   // fetch in flight
	logic [3:0] wait_n; // cycles left
	logic [7:0] addr_q; // latched address
	// ------------------------------------------------------------
	// fetch sequencer: prompt for aspm word, slow for latency word
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		nvm_ack <= 1'h0;
		nvm_data <= ~nvm_data; // stale data keeps changing
		if (rst) begin
			busy <= 1'h0;
			nvm_data <= 16'h5A5A;
		end else if (!busy && nvm_rd) begin
			busy <= 1'h1;
			addr_q <= nvm_addr;
			wait_n <= (nvm_addr == plcap_pkg::NVM_ASPM_WORD) ? 4'h0 : 4'h6;
		end else if (busy && wait_n != 4'h0) begin
			wait_n <= wait_n - 4'h1;
		end else if (busy) begin
			busy <= 1'h0;
			nvm_ack <= 1'h1;
			nvm_data <= (addr_q == plcap_pkg::NVM_ASPM_WORD) ?
				ASPM_WORD : LAT_WORD;
		end
	end
endmodule : plcap_nvm_model
`default_nettype wire

/* File: sim/pcie_link_capability_register_bench.sv */
// pcie_link_capability_register_bench: self-checking register bench
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin \
	n_mismatch++; \
	$display("wrong value %s exp %h got %h", nm, exp, got); end end
module pcie_link_capability_register_bench;
	logic        clk_sys = 1'h0;   // system clock
	logic        rst = 1'h1;       // sync reset
	logic        cfg_rd = 1'h0;    // read request
	logic        cfg_wr = 1'h0;    // write request
	logic [11:0] cfg_addr = 12'h000; // byte offset
	logic [31:0] cfg_wdata = 32'h0; // write data
	logic        cfg_ack;          // answer pulse
	logic [31:0] cfg_rdata;        // read data
	logic        common_clk = 1'h1; // clock mode
	logic        link_training = 1'h0; // training level
	logic        port_valid = 1'h0; // port strobe
	logic [7:0]  port_num = 8'h00; // port number
	logic        nvm_rd;           // nvm strobe
	logic [7:0]  nvm_addr;         // nvm address
	logic        nvm_ack;          // nvm answer
	logic [15:0] nvm_data;         // nvm word
	logic        cap_ready;        // fields loaded
	int          n_mismatch = 0;   // mismatches
	int          check_count = 0;  // comparisons
	int          cycles = 0;       // cycle counter
	logic [31:0] rd;               // last read value
	// expected images from the model's nvm words
	localparam logic [31:0] IMG_COMMON = 32'h00022411;
	localparam logic [31:0] IMG_SEP    = 32'h00025411;
	always #2 clk_sys = ~clk_sys;
	plcap_link_capabilities u_plcap_link_capabilities (.clk_sys(clk_sys), .rst(rst),
		.cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
		.cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
		.common_clk(common_clk), .link_training(link_training),
		.port_valid(port_valid), .port_num(port_num), .nvm_rd(nvm_rd),
		.nvm_addr(nvm_addr), .nvm_ack(nvm_ack), .nvm_data(nvm_data),
		.cap_ready(cap_ready));
	plcap_nvm_model u_plcap_nvm_model (.clk_sys(clk_sys), .rst(rst),
		.nvm_rd(nvm_rd), .nvm_addr(nvm_addr), .nvm_ack(nvm_ack),
		.nvm_data(nvm_data));
	// ------------------------------------------------------------
	// closing report
	// ------------------------------------------------------------
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	// hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	// one config access, waits for the answer pulse
	task automatic cfg_op(input logic wr, input logic [11:0] addr);
		int n;
		n = 0;
		@(posedge clk_sys);
		cfg_rd <= !wr;
		cfg_wr <= wr;
		cfg_addr <= addr;
		@(posedge clk_sys);
		cfg_rd <= 1'h0;
		cfg_wr <= 1'h0;
		#1;
		while (cfg_ack !== 1'h1 && n < 60) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		rd = cfg_rdata;
		`CHK("cfg_ack", 1'h1, cfg_ack)
	endtask : cfg_op
	// read issued before load completes, answered with loaded fields
	task automatic test_early;
		repeat (3) @(posedge clk_sys);
		rst <= 1'h0;
		#1;
		`CHK("nvm_rd", 1'h1, nvm_rd)
		`CHK("nvm_addr", plcap_pkg::NVM_ASPM_WORD, nvm_addr)
		`CHK("ready early", 1'h0, cap_ready)
		cfg_op(1'h0, plcap_pkg::LINK_CAPABILITIES_OFS);
		`CHK("cap_ready", 1'h1, cap_ready)
		`CHK("speed width", 10'h011, rd[9:0])
		`CHK("absent caps", 6'h00, rd[23:18])
		`CHK("port", 8'h00, rd[31:24])
		`CHK("image", IMG_COMMON, rd)
		$display("test early done");
	endtask : test_early
	// separate clock selects the other l0s value
	task automatic test_clock;
		@(posedge clk_sys);
		common_clk <= 1'h0;
		cfg_op(1'h0, plcap_pkg::LINK_CAPABILITIES_OFS);
		`CHK("l0s separate", IMG_SEP, rd)
		@(posedge clk_sys);
		common_clk <= 1'h1;
		cfg_op(1'h0, plcap_pkg::LINK_CAPABILITIES_OFS);
		`CHK("l0s common", IMG_COMMON, rd)
		$display("test clock done");
	endtask : test_clock
	// writes change nothing, other offsets read zero
	task automatic test_write;
		@(posedge clk_sys);
		cfg_wdata <= 32'hFFFFFFFF;
		cfg_op(1'h1, plcap_pkg::LINK_CAPABILITIES_OFS);
		`CHK("write answer", 32'h00000000, rd)
		cfg_op(1'h0, plcap_pkg::LINK_CAPABILITIES_OFS);
		`CHK("after write", IMG_COMMON, rd)
		cfg_op(1'h0, 12'h0F0);
		`CHK("other offset", 32'h00000000, rd)
		$display("test write done");
	endtask : test_write
	// port number captured during training, kept afterwards
	task automatic test_port;
		@(posedge clk_sys);
		link_training <= 1'h1;
		port_valid <= 1'h1;
		port_num <= 8'hA5;
		repeat (12) @(posedge clk_sys);
		link_training <= 1'h0;
		port_valid <= 1'h0;
		repeat (12) @(posedge clk_sys);
		// strobe outside training must be ignored
		port_valid <= 1'h1;
		port_num <= 8'h3C;
		repeat (12) @(posedge clk_sys);
		port_valid <= 1'h0;
		cfg_op(1'h0, plcap_pkg::LINK_CAPABILITIES_OFS);
		`CHK("port", {8'hA5, IMG_COMMON[23:0]}, rd)
		$display("test port done");
	endtask : test_port
	// mid-run reset restores defaults and reloads the nvm fields
	task automatic test_reset;
		@(posedge clk_sys);
		rst <= 1'h1;
		repeat (3) @(posedge clk_sys);
		rst <= 1'h0;
		#1;
		`CHK("ready after reset", 1'h0, cap_ready)
		`CHK("refetch addr", plcap_pkg::NVM_ASPM_WORD, nvm_addr)
		cfg_op(1'h0, plcap_pkg::LINK_CAPABILITIES_OFS);
		`CHK("image after reset", IMG_COMMON, rd)
		$display("test reset done");
	endtask : test_reset
	// main sequence
	initial begin
		test_early();
		test_clock();
		test_write();
		test_port();
		test_reset();
		tally_and_finish();
	end
endmodule : pcie_link_capability_register_bench
`default_nettype wire
